// ===== verilog/pca_pkg.sv
// package: constants and types for the programmable counter array
package pca_pkg;
	// ==========================================================
	// geometry
	localparam int          PCA_NMOD    = 6;
	localparam int          PCA_CW      = 16;
	localparam int          PCA_WDT_MOD = 5;
	// ==========================================================
	// clock source select codes
	localparam logic [2:0]  PCA_CPS_DIV12 = 3'h0;
	localparam logic [2:0]  PCA_CPS_DIV4  = 3'h1;
	localparam logic [2:0]  PCA_CPS_T0OV  = 3'h2;
	localparam logic [2:0]  PCA_CPS_EXT   = 3'h3;
	localparam logic [2:0]  PCA_CPS_SYS   = 3'h4;
	localparam logic [2:0]  PCA_CPS_XOSC8 = 3'h5;
	localparam logic [2:0]  PCA_CPS_RTC8  = 3'h6;
	// ==========================================================
	// prescale terminal counts
	localparam logic [3:0]  PCA_DIV12_TC  = 4'hB;
	localparam logic [3:0]  PCA_DIV4_TC   = 4'h3;
	localparam logic [3:0]  PCA_DIV8_TC   = 4'h7;
	// ==========================================================
	// reset values
	localparam logic [15:0] PCA_CNT_RST   = 16'h0000;
	localparam logic [15:0] PCA_WDT_RST   = 16'hFFFF;
	// ==========================================================
	// module modes
	typedef enum logic [2:0] {
		PCA_M_OFF, PCA_M_CAPTURE, PCA_M_SWTIMER, PCA_M_HSO,
		PCA_M_FREQ, PCA_M_PWM, PCA_M_PWM16
	} pca_mode_t;
endpackage : pca_pkg

// ===== verilog/pca_module.sv
// single capture/compare module
`timescale 1ns/1ps
`default_nettype none
module pca_module
	import pca_pkg::*;
(
	// clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	// time base
	input  wire logic              i_tick,
	input  wire logic [15:0]       i_count,
	input  wire logic              i_ovf8,
	// configuration
	input  wire pca_mode_t         i_mode,
	input  wire logic [3:0]        i_pwm_bits,
	input  wire logic              i_cap_pos,
	input  wire logic              i_cap_neg,
	input  wire logic [15:0]       i_cmp,
	// capture input, already synchronised
	input  wire logic              i_pin_sync,
	// results
	output logic [15:0]            o_capture,
	output logic                   o_match,
	output logic                   o_out
);
	// ==========================================================
	// decode
	logic        prev_reg;
	logic [15:0] pwm_mask;
	logic        rise;
	logic        fall;
	logic        is_cap;
	logic        hit;
	logic        pwm_low;
	assign rise     = i_pin_sync & ~prev_reg;
	assign fall     = ~i_pin_sync & prev_reg;
	assign is_cap   = (i_mode == PCA_M_CAPTURE) && ((rise && i_cap_pos) || (fall && i_cap_neg));
	assign pwm_mask = (i_mode == PCA_M_PWM16) ? 16'hFFFF : 16'((17'h1 << i_pwm_bits) - 17'h1);
	assign hit      = i_tick && (((i_count + 16'h0001) & pwm_mask) == (i_cmp & pwm_mask));
	assign pwm_low  = (i_count & pwm_mask) < (i_cmp & pwm_mask);
	// ==========================================================
	// state
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_reg  <= 1'b0;
			o_capture <= 16'h0000;
			o_match   <= 1'b0;
			o_out     <= 1'b0;
		end else if (i_ce) begin
			prev_reg <= i_pin_sync;
			o_match  <= 1'b0;
			if (is_cap) begin
				o_capture <= i_count; // RULE10
				o_match   <= 1'b1;
			end
			case (i_mode)
				PCA_M_SWTIMER: o_match <= hit;
				PCA_M_HSO: begin
					o_match <= hit;
					if (hit)
						o_out <= ~o_out;
				end
				PCA_M_FREQ: begin
					if (i_tick && i_ovf8)
						o_out <= ~o_out;
				end
				PCA_M_PWM, PCA_M_PWM16: o_out <= ~pwm_low; // RULE4
				default: ;
			endcase
		end
	end
endmodule : pca_module
`default_nettype wire

// ===== verilog/pca_top.sv
// programmable counter array: shared time base, six modules, watchdog
// What this block does
// [RULE1] one 16-bit counter feeds six modules
// [RULE2] six selectable counter clock sources
// [RULE3] larger variants add rtc divided by eight
// [RULE4] capture, timer, fast output, frequency, pwm
// [RULE5] module five can act as watchdog
// [RULE6] watchdog enabled after every system reset
// [RULE7] watchdog lockable off until next system reset or power-on
// [RULE8] watchdog reset source maskable by software
// [RULE9] module pins and count input reach crossbar
// [RULE10] inputs synchronised, edges detected before use
`timescale 1ns/1ps
`default_nettype none
module pca_top
	import pca_pkg::*;
#(
	parameter bit HAS_RTC = 1'b1
)(
	// clock and reset
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_por,
	input  wire logic                   i_ce,
	// counter control
	input  wire logic                   i_run,
	input  wire logic [2:0]             i_clk_sel,
	input  wire logic                   i_cnt_wr,
	input  wire logic [15:0]            i_cnt_wdata,
	input  wire logic                   i_t0_ovf,
	input  wire logic                   i_xosc_clk,
	input  wire logic                   i_rtc_clk,
	// per module configuration, packed by module index
	input  wire logic [6*3-1:0]         i_mode,
	input  wire logic [6*4-1:0]         i_pwm_bits,
	input  wire logic [5:0]             i_cap_pos,
	input  wire logic [5:0]             i_cap_neg,
	input  wire logic [6*16-1:0]        i_cmp,
	// watchdog control
	input  wire logic                   i_wdt_disable,
	input  wire logic                   i_wdt_lock,
	input  wire logic                   i_wdt_kick,
	input  wire logic                   i_wdt_rst_mask,
	// crossbar pins
	input  wire logic                   i_external_count_input,
	input  wire logic [5:0]             i_cex,
	output logic [5:0]                  o_cex,
	// status
	output logic [15:0]                 o_count,
	output logic                        o_cnt_ovf,
	output logic [5:0]                  o_match,
	output logic [6*16-1:0]             o_capture,
	output logic                        o_wdt_active,
	output logic                        o_wdt_rst
);
	// ==========================================================
	// input synchronisers
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [1:0] xosc_s_reg;
	logic [1:0] rtc_s_reg;
	logic       eci_prev_reg;
	logic       xosc_prev_reg;
	logic       rtc_prev_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_reg  <= 7'h00;
			sync2_reg  <= 7'h00;
			xosc_s_reg <= 2'h0;
			rtc_s_reg  <= 2'h0;
		end else if (i_ce) begin
			sync1_reg  <= {i_external_count_input, i_cex}; // RULE10 RULE9
			sync2_reg  <= sync1_reg;
			xosc_s_reg <= {xosc_s_reg[0], i_xosc_clk};
			rtc_s_reg  <= {rtc_s_reg[0], i_rtc_clk};
		end
	end
	// ==========================================================
	// prescalers and source select
	logic [3:0] pre_reg;
	logic [2:0] xdiv_reg;
	logic [2:0] rdiv_reg;
	logic       eci_edge;
	logic       xosc_edge;
	logic       rtc_edge;
	logic       tick;
	assign eci_edge  = sync2_reg[6] & ~eci_prev_reg; // RULE10
	assign xosc_edge = xosc_s_reg[1] & ~xosc_prev_reg;
	assign rtc_edge  = rtc_s_reg[1] & ~rtc_prev_reg;
	assign tick = i_run && ( // RULE2 RULE3
		(i_clk_sel == PCA_CPS_DIV12 && pre_reg >= PCA_DIV12_TC) ||
		(i_clk_sel == PCA_CPS_DIV4 && pre_reg[1:0] == PCA_DIV4_TC[1:0]) ||
		(i_clk_sel == PCA_CPS_T0OV && i_t0_ovf) ||
		(i_clk_sel == PCA_CPS_EXT && eci_edge) ||
		(i_clk_sel == PCA_CPS_SYS) ||
		(i_clk_sel == PCA_CPS_XOSC8 && xosc_edge && xdiv_reg == PCA_DIV8_TC[2:0]) ||
		(HAS_RTC && i_clk_sel == PCA_CPS_RTC8 && rtc_edge && rdiv_reg == PCA_DIV8_TC[2:0]));
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre_reg       <= 4'h0;
			xdiv_reg      <= 3'h0;
			rdiv_reg      <= 3'h0;
			eci_prev_reg  <= 1'b0;
			xosc_prev_reg <= 1'b0;
			rtc_prev_reg  <= 1'b0;
		end else if (i_ce) begin
			pre_reg       <= (pre_reg >= PCA_DIV12_TC) ? 4'h0 : pre_reg + 4'h1;
			eci_prev_reg  <= sync2_reg[6];
			xosc_prev_reg <= xosc_s_reg[1];
			rtc_prev_reg  <= rtc_s_reg[1];
			if (xosc_edge)
				xdiv_reg <= xdiv_reg + 3'h1;
			if (rtc_edge)
				rdiv_reg <= rdiv_reg + 3'h1;
		end
	end
	// ==========================================================
	// shared time base
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count   <= PCA_CNT_RST;
			o_cnt_ovf <= 1'b0;
		end else if (i_ce) begin
			o_cnt_ovf <= tick && !i_cnt_wr && (o_count == 16'hFFFF);
			if (i_cnt_wr)
				o_count <= i_cnt_wdata;
			else if (tick)
				o_count <= o_count + 16'h0001; // RULE1
		end
	end
	// ==========================================================
	// capture/compare modules
	logic [5:0] mod_match;
	logic [5:0] mod_out;
	generate
		for (genvar m = 0; m < PCA_NMOD; m++) begin : g_mod
			pca_module u_mod (
				.i_core_clk (i_core_clk),
				.i_rst_n    (i_rst_n),
				.i_ce       (i_ce),
				.i_tick     (tick),
				.i_count    (o_count),
				.i_ovf8     (o_count[7:0] == 8'hFF),
				.i_mode     (pca_mode_t'(i_mode[m*3 +: 3])), // RULE4
				.i_pwm_bits (i_pwm_bits[m*4 +: 4]),
				.i_cap_pos  (i_cap_pos[m]),
				.i_cap_neg  (i_cap_neg[m]),
				.i_cmp      (i_cmp[m*16 +: 16]),
				.i_pin_sync (sync2_reg[m]),
				.o_capture  (o_capture[m*16 +: 16]),
				.o_match    (mod_match[m]),
				.o_out      (mod_out[m])
			);
		end
	endgenerate
	// ==========================================================
	// watchdog on module five
	logic        wdt_en_reg;
	logic        wdt_lock_reg;
	logic [15:0] wdt_cnt_reg;
	logic        wdt_hit;
	assign wdt_hit = wdt_en_reg && tick && (wdt_cnt_reg == 16'h0000);
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdt_en_reg   <= 1'b1; // RULE6
			wdt_lock_reg <= 1'b0;
			wdt_cnt_reg  <= PCA_WDT_RST;
			o_wdt_rst    <= 1'b0;
		end else if (i_ce) begin
			if (i_por) begin
				wdt_lock_reg <= 1'b0; // RULE7
				wdt_en_reg   <= 1'b1;
			end else if (i_wdt_disable && i_wdt_lock) begin
				wdt_lock_reg <= 1'b1; // RULE7
				wdt_en_reg   <= 1'b0;
			end else if (!wdt_lock_reg) begin
				wdt_en_reg <= ~i_wdt_disable;
			end
			// reload after a timeout too, so the reset is one pulse
			if (i_wdt_kick || !wdt_en_reg || wdt_hit)
				wdt_cnt_reg <= i_cmp[PCA_WDT_MOD*16 +: 16];
			else if (tick && wdt_cnt_reg != 16'h0000)
				wdt_cnt_reg <= wdt_cnt_reg - 16'h0001; // RULE5
			o_wdt_rst <= wdt_hit && !i_wdt_rst_mask; // RULE8
		end
	end
	assign o_wdt_active = wdt_en_reg;
	assign o_match = mod_match;
	assign o_cex   = mod_out; // RULE9
endmodule : pca_top
`default_nettype wire

// ===== sim/pca_sva.sv
// checker: port level assertions for the counter array
`timescale 1ns/1ps
`default_nettype none
module pca_sva
	import pca_pkg::*;
(
	input wire logic        i_core_clk, i_rst_n, i_por, i_ce, i_run, i_cnt_wr,
	input wire logic [2:0]  i_clk_sel,
	input wire logic [15:0] i_cnt_wdata, o_count,
	input wire logic        i_wdt_disable, i_wdt_rst_mask, o_cnt_ovf, o_wdt_active, o_wdt_rst,
	input wire logic [5:0]  o_match
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_cnt_step: assert property (i_ce && i_run && !i_cnt_wr && i_clk_sel == PCA_CPS_SYS
		|=> o_count == $past(o_count) + 16'h0001) else $error("count did not step");
	a_cnt_load: assert property (i_ce && i_cnt_wr |=> o_count == $past(i_cnt_wdata))
		else $error("count load lost");
	a_ce_hold: assert property (!i_ce |=> $stable(o_count) && $stable(o_cnt_ovf))
		else $error("count moved while frozen");
	a_ovf_wrap: assert property (o_cnt_ovf |-> o_count == 16'h0000)
		else $error("overflow without wrap");
	a_wdt_init: assert property ($rose(i_rst_n) |-> o_wdt_active && o_count == PCA_CNT_RST)
		else $error("watchdog not armed after reset");
	a_wdt_pulse: assert property (o_wdt_rst && i_ce |=> !o_wdt_rst)
		else $error("watchdog reset longer than one cycle");
	a_wdt_gate: assert property (o_wdt_rst |-> $past(o_wdt_active))
		else $error("reset from idle watchdog");
	a_wdt_mask: assert property (i_wdt_rst_mask [*2] |-> !o_wdt_rst)
		else $error("masked watchdog reset seen");
	a_wdt_off: assert property (i_wdt_disable && !o_wdt_active |=> !o_wdt_active)
		else $error("watchdog came back on");
	a_por_arm: assert property (i_por && i_ce |=> o_wdt_active)
		else $error("power-on did not rearm watchdog");
	c_wdt: cover property (o_wdt_rst);
	c_ovf: cover property (o_cnt_ovf);
	c_cap: cover property (o_match[0]);
endmodule : pca_sva
bind pca_top pca_sva u_sva (.i_core_clk, .i_rst_n, .i_por, .i_ce, .i_run, .i_cnt_wr, .i_clk_sel,
	.i_cnt_wdata, .o_count, .i_wdt_disable, .i_wdt_rst_mask, .o_cnt_ovf, .o_wdt_active,
	.o_wdt_rst, .o_match);
`default_nettype wire

// ===== sim/pca_pin_model.sv
// partner model: crossbar pins for count input and module pins
`timescale 1ns/1ps
`default_nettype none
module pca_pin_model (
	input  wire logic       i_core_clk,
	input  wire logic [5:0] i_cex_req,
	output logic            o_eci,
	output logic [5:0]      o_cex
);
	logic [2:0] div_reg = 3'h0;
	always @(posedge i_core_clk) begin
		div_reg <= div_reg + 3'h1;
		o_eci   <= div_reg[2];
		o_cex   <= i_cex_req;
	end
endmodule : pca_pin_model
`default_nettype wire

// ===== sim/pca_top_tb.sv
// testbench for the programmable counter array
`timescale 1ns/1ps
`default_nettype none
module pca_top_tb;
	import pca_pkg::*;
	typedef struct {logic [2:0] sel; logic [15:0] exp;} pca_row_t;
	logic        i_core_clk = 0, i_rst_n = 0, i_por = 1, i_ce = 1, i_run = 0, i_cnt_wr = 0;
	logic        i_t0_ovf = 0, i_xosc_clk = 0, i_rtc_clk = 0, i_external_count_input;
	logic        i_wdt_disable = 0, i_wdt_lock = 0, i_wdt_kick = 0, i_wdt_rst_mask = 0;
	logic [2:0]  i_clk_sel = 0;
	logic [15:0] i_cnt_wdata = 0, o_count;
	logic [17:0] i_mode = {PCA_M_PWM16, PCA_M_PWM, PCA_M_FREQ, PCA_M_HSO, PCA_M_SWTIMER,
		PCA_M_CAPTURE};
	logic [23:0] i_pwm_bits = 24'h00_0000;
	logic [5:0]  i_cap_pos = 6'h01, i_cap_neg = 6'h00, i_cex, o_cex, o_match, cex_req = 0;
	logic [95:0] i_cmp = {16'h0010, 16'h0040, 64'h0}, o_capture;
	logic        o_cnt_ovf, o_wdt_active, o_wdt_rst;
	logic [15:0] frz;
	int          error_cnt = 0, checks_done = 0, hits, cyc = 0;
	pca_row_t    rows[7] = '{'{PCA_CPS_DIV12, 16'h0008}, '{PCA_CPS_DIV4, 16'h0018},
		'{PCA_CPS_T0OV, 16'h0010}, '{PCA_CPS_EXT, 16'h000C}, '{PCA_CPS_SYS, 16'h0060},
		'{PCA_CPS_XOSC8, 16'h0003}, '{PCA_CPS_RTC8, 16'h0003}};
	pca_top #(.HAS_RTC(1'b1)) DUT (.*);
	pca_pin_model u_pins (.i_core_clk, .i_cex_req(cex_req), .o_eci(i_external_count_input),
		.o_cex(i_cex));
	initial forever #2 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc        <= cyc + 1;
		i_t0_ovf   <= (cyc % 6 == 0);
		i_xosc_clk <= cyc[1];
		i_rtc_clk  <= cyc[1];
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp && got !== exp + 16'h0001 && got !== exp - 16'h0001) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_rng
	// counts pulses of one watched output over n cycles
	task automatic watch(input int s, input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(negedge i_core_clk);
			cnt += (s == 0) ? o_cnt_ovf : (s == 1) ? o_match[0] : o_wdt_rst;
		end
	endtask : watch
	task automatic complete_run();
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		#200000;
		error_cnt++;
		complete_run();
	end
	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rst_n <= 1;
		@(negedge i_core_clk);
		chk({15'h0, o_wdt_active}, 16'h0001);
		chk(o_count, PCA_CNT_RST);
		i_por <= 0;
		foreach (rows[k]) begin
			@(posedge i_core_clk);
			i_clk_sel   <= rows[k].sel;
			i_cnt_wr    <= 1;
			i_cnt_wdata <= 16'h0000;
			i_run       <= 1;
			@(posedge i_core_clk);
			i_cnt_wr <= 0;
			repeat (96) @(posedge i_core_clk);
			i_run <= 0;
			@(negedge i_core_clk);
			chk_rng(o_count, rows[k].exp);
		end
		frz = o_count;
		@(posedge i_core_clk);
		i_clk_sel   <= PCA_CPS_SYS;
		i_cnt_wr    <= 1;
		i_cnt_wdata <= 16'hFFFA;
		i_run       <= 1;
		i_ce        <= 0;
		repeat (3) @(posedge i_core_clk);
		i_ce <= 1;
		@(negedge i_core_clk);
		chk(o_count, frz);
		@(posedge i_core_clk);
		i_cnt_wr <= 0;
		watch(0, 10, hits);
		chk(16'(hits), 16'h0001);
		cex_req <= 6'h01;
		watch(1, 10, hits);
		chk(16'(hits), 16'h0001);
		@(posedge i_core_clk);
		i_wdt_kick <= 1;
		@(posedge i_core_clk);
		i_wdt_kick <= 0;
		watch(2, 30, hits);
		chk(16'(hits), 16'h0001);
		i_wdt_rst_mask <= 1;
		i_wdt_kick     <= 1;
		@(posedge i_core_clk);
		i_wdt_kick <= 0;
		watch(2, 60, hits);
		chk(16'(hits), 16'h0000);
		i_wdt_disable <= 1;
		i_wdt_lock    <= 1;
		repeat (2) @(posedge i_core_clk);
		i_wdt_disable <= 0;
		i_wdt_lock    <= 0;
		repeat (4) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk({15'h0, o_wdt_active}, 16'h0000);
		i_por   <= 1;
		i_rst_n <= 0;
		repeat (5) @(posedge i_core_clk);
		i_rst_n <= 1;
		@(negedge i_core_clk);
		chk({15'h0, o_wdt_active}, 16'h0001);
		complete_run();
	end
endmodule : pca_top_tb
`default_nettype wire
